// ---- shared/sld_pkg.sv ----
// constants for the segment lcd driver: register map, fields, timing
// assumes a 50 MHz aclk and an axi4-lite register bus
`default_nettype none
package sld_pkg;
	// ****************************************
	// register map
	// ****************************************
	// printed offsets are not word multiples: index kept, byte = 4 * index
	localparam logic [11:0] VOLT_IDX      = 12'h089;
	localparam logic [11:0] MODE_IDX      = 12'h0CB;
	localparam logic [11:0] RAM_IDX_BASE  = 12'h500;
	localparam logic [13:0] VOLT_ADDR     = {VOLT_IDX, 2'b00};
	localparam logic [13:0] MODE_ADDR     = {MODE_IDX, 2'b00};
	localparam logic [13:0] RAM_ADDR_BASE = {RAM_IDX_BASE, 2'b00};
	localparam int          RAM_WORDS     = 32;
	localparam logic [7:0]  MODE_RESET    = 8'h00;
	localparam logic [7:0]  VOLT_RESET    = 8'h00;
	localparam logic [7:0]  MODE_MASK     = 8'h0F;
	localparam logic [7:0]  VOLT_MASK     = 8'h3F;
	// ****************************************
	// field positions
	// ****************************************
	localparam int MODE_RCCLK_BIT = 3;
	localparam int MODE_SHARE_BIT = 2;
	localparam int MODE_BIAS_BIT  = 1;
	localparam int MODE_ON_BIT    = 0;
	localparam int VOLT_CK_HI     = 5;
	localparam int VOLT_CK_LO     = 4;
	localparam int VOLT_LV_HI     = 3;
	localparam int VOLT_LV_LO     = 1;
	localparam int VOLT_PUMP_BIT  = 0;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ        = 50000000;
	localparam int LOSC_HZ       = 32768;
	localparam int FRAME_HZ      = 64;
	localparam int PHASES        = 4;
	// ticks of the low-speed clock per common phase
	localparam int LOSC_PER_PHASE = LOSC_HZ / (FRAME_HZ * PHASES);
	// pump clock dividers of the 32768 Hz source: 32k,16k,4k,1k
	localparam int PUMP_DIV0 = 1;
	localparam int PUMP_DIV1 = 2;
	localparam int PUMP_DIV2 = 8;
	localparam int PUMP_DIV3 = 32;
	// ****************************************
	// bus responses
	// ****************************************
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// drive level codes (2 bits) of one lcd pin
	localparam logic [1:0] LVL_GND = 2'b00;
	localparam logic [1:0] LVL_V1  = 2'b01;
	localparam logic [1:0] LVL_V2  = 2'b10;
	localparam logic [1:0] LVL_TOP = 2'b11;
	typedef enum logic [1:0] {
		SLD_IDLE = 2'b00,
		SLD_RUN  = 2'b01
	} sld_seq_e;
endpackage : sld_pkg
`default_nettype wire

// ---- hdl/sld_ram.sv ----
// display memory, 32 bytes, one per segment; registered read port
// assumes one write and one read port on aclk; scan port is registered too
`default_nettype none
module sld_ram
	import sld_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       we,
	input  wire logic [4:0] waddr,
	input  wire logic [7:0] wdata,
	input  wire logic [4:0] raddr,
	output logic      [7:0] rdata,
	output logic      [RAM_WORDS*4-1:0] dots
);
	logic [7:0] mem [RAM_WORDS];

	// ****************************************
	// storage
	// ****************************************
	// no reset: contents are undefined at power up, as in a real ram
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

	// low nibble of every byte feeds the scan; upper nibble is ignored
	always_ff @(posedge aclk) begin
		for (int i = 0; i < RAM_WORDS; i++) begin
			dots[i*4 +: 4] <= mem[i][3:0];
		end
	end
endmodule : sld_ram
`default_nettype wire

// ---- hdl/sld_top.sv ----
// segment lcd driver: axi4-lite registers, display ram, common scan
// assumes aclk at 50 MHz and a 32768 Hz low-speed clock on losc_pin
//
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none
module sld_top
	import sld_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [13:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [13:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        losc_pin,
	output logic      [7:0]  common_lines,
	output logic      [63:0] segment_line,
	output logic             port3_segment_share,
	output logic             losc_rc_sel,
	output logic             panel_half_bias,
	output logic      [1:0]  pump_clock_sel,
	output logic      [2:0]  pump_level_sel,
	output logic             pump_enable,
	output logic             pump_clk_en
);
	// ****************************************
	// register bus
	// ****************************************
	logic [7:0]  panel_mode_reg;
	logic [7:0]  pump_voltage_reg;
	logic [13:0] aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic        w_strb0;
	logic        w_held;
	logic        ram_we;
	logic [4:0]  ram_waddr;
	logic [7:0]  ram_rdata;
	logic [4:0]  ram_raddr;
	logic [RAM_WORDS*4-1:0] dots;
	logic [13:0] ar_addr;
	logic        rd_wait;
	logic        rd_late;
	logic        wr_ram_hit;
	logic        wr_hit;
	logic        rd_ram_hit;
	logic        panel_driver_on;

	assign panel_driver_on = panel_mode_reg[MODE_ON_BIT];
	// ram spans 32 words from the base; bits 6:2 pick the segment
	assign wr_ram_hit = (aw_addr[13:7] == RAM_ADDR_BASE[13:7]);
	assign wr_hit     = wr_ram_hit || aw_addr == MODE_ADDR
		|| aw_addr == VOLT_ADDR;
	assign rd_ram_hit = (ar_addr[13:7] == RAM_ADDR_BASE[13:7]);

	// write address and data held independently, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb0 <= 1'b0;
		end else if (aw_held && w_held && !s_axi_bvalid) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held  <= 1'b1;
				w_data  <= s_axi_wdata;
				w_strb0 <= s_axi_wstrb[0];
			end
		end
	end

	// ready only while the slot is empty and no response waits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_bvalid
				&& !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held && !s_axi_bvalid
				&& !(s_axi_wvalid && s_axi_wready);
		end
	end

	// commit and respond; unmapped writes are answered with slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (aw_held && w_held && !s_axi_bvalid) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control registers; unused high bits stay zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			panel_mode_reg   <= MODE_RESET;
			pump_voltage_reg <= VOLT_RESET;
		end else if (aw_held && w_held && !s_axi_bvalid && w_strb0) begin
			if (aw_addr == MODE_ADDR) begin
				panel_mode_reg <= w_data[7:0] & MODE_MASK;
			end
			if (aw_addr == VOLT_ADDR) begin
				pump_voltage_reg <= w_data[7:0] & VOLT_MASK;
			end
		end
	end

	assign ram_we    = aw_held && w_held && !s_axi_bvalid && w_strb0
		&& wr_ram_hit;
	assign ram_waddr = aw_addr[6:2];

	// read channel: address taken, ram read next cycle, answer after that;
	// the extra stage keeps the registered ram output from being stale
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			ar_addr       <= '0;
			rd_wait       <= 1'b0;
			rd_late       <= 1'b0;
		end else begin
			s_axi_arready <= !rd_wait && !rd_late && !s_axi_rvalid
				&& !(s_axi_arvalid && s_axi_arready);
			rd_late       <= rd_wait;
			if (s_axi_arvalid && s_axi_arready) begin
				ar_addr <= s_axi_araddr;
				rd_wait <= 1'b1;
			end else if (rd_wait) begin
				rd_wait <= 1'b0;
			end
		end
	end
	assign ram_raddr = ar_addr[6:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_late) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			if (rd_ram_hit) begin
				s_axi_rdata <= {24'h000000, ram_rdata};
			end else if (ar_addr == MODE_ADDR) begin
				s_axi_rdata <= {24'h000000, panel_mode_reg};
			end else if (ar_addr == VOLT_ADDR) begin
				s_axi_rdata <= {24'h000000, pump_voltage_reg};
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	sld_ram u_ram (
		.aclk  (aclk),
		.we    (ram_we),
		.waddr (ram_waddr),
		.wdata (w_data[7:0]),
		.raddr (ram_raddr),
		.rdata (ram_rdata),
		.dots  (dots)
	);

	// ****************************************
	// control outputs
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			losc_rc_sel         <= 1'b0;
			port3_segment_share <= 1'b0;
			panel_half_bias     <= 1'b0;
			pump_clock_sel      <= 2'b00;
			pump_level_sel      <= 3'b000;
			pump_enable         <= 1'b0;
		end else begin
			losc_rc_sel         <= panel_mode_reg[MODE_RCCLK_BIT];
			port3_segment_share <= panel_mode_reg[MODE_SHARE_BIT];
			panel_half_bias     <= panel_mode_reg[MODE_BIAS_BIT];
			pump_clock_sel      <=
				pump_voltage_reg[VOLT_CK_HI:VOLT_CK_LO];
			pump_level_sel      <=
				pump_voltage_reg[VOLT_LV_HI:VOLT_LV_LO];
			pump_enable         <= pump_voltage_reg[VOLT_PUMP_BIT];
		end
	end

	// ****************************************
	// low-speed clock sampling
	// ****************************************
	logic [2:0] losc_sync;
	logic       losc_tick;

	// two flops before use; third flop only for edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			losc_sync <= 3'b000;
		end else begin
			losc_sync <= {losc_sync[1:0], losc_pin};
		end
	end
	assign losc_tick = losc_sync[1] && !losc_sync[2];

	// pump clock enable: 32768 Hz divided by 1, 2, 8 or 32
	logic [4:0] pump_div;
	logic [4:0] pump_last;
	always_comb begin
		case (pump_clock_sel)
			2'b00:   pump_last = 5'(PUMP_DIV0 - 1);
			2'b01:   pump_last = 5'(PUMP_DIV1 - 1);
			2'b10:   pump_last = 5'(PUMP_DIV2 - 1);
			default: pump_last = 5'(PUMP_DIV3 - 1);
		endcase
	end
	// pulse runs only with the pump on; the analog pump is outside
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pump_div    <= '0;
			pump_clk_en <= 1'b0;
		end else begin
			pump_clk_en <= 1'b0;
			if (!pump_enable) begin
				pump_div <= '0;
			end else if (losc_tick) begin
				if (pump_div >= pump_last) begin
					pump_div    <= '0;
					pump_clk_en <= 1'b1;
				end else begin
					pump_div <= pump_div + 5'd1;
				end
			end
		end
	end

	// ****************************************
	// frame sequencer
	// ****************************************
	sld_seq_e   seq_state;
	logic [6:0] phase_cnt;
	logic [1:0] phase;
	logic       invert;

	// 128 low-speed ticks per phase, 4 phases, alternating polarity
	// frames so the panel sees no dc; one frame = 512 ticks = 64 Hz
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_state <= SLD_IDLE;
			phase_cnt <= '0;
			phase     <= 2'd0;
			invert    <= 1'b0;
		end else begin
			case (seq_state)
				SLD_IDLE: begin
					phase_cnt <= '0;
					phase     <= 2'd0;
					invert    <= 1'b0;
					if (panel_driver_on) begin
						seq_state <= SLD_RUN;
					end
				end
				SLD_RUN: begin
					if (!panel_driver_on) begin
						seq_state <= SLD_IDLE;
					end else if (losc_tick) begin
						if (phase_cnt == 7'(LOSC_PER_PHASE - 1)) begin
							phase_cnt <= '0;
							phase     <= phase + 2'd1;
							if (phase == 2'd3) begin
								invert <= !invert;
							end
						end else begin
							phase_cnt <= phase_cnt + 7'd1;
						end
					end
				end
				default: seq_state <= SLD_IDLE;
			endcase
		end
	end

	// ****************************************
	// pin drive levels
	// ****************************************
	// selected common at top (or gnd), others at the mid level;
	// segment on = opposite extreme, off = near level. half bias merges
	// v1 and v2 into one mid level
	logic [1:0] off_seg;
	logic [1:0] mid_com;
	assign mid_com = panel_half_bias ? LVL_V1 : (invert ? LVL_V2 : LVL_V1);
	assign off_seg = panel_half_bias ? LVL_V1 : (invert ? LVL_V1 : LVL_V2);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			common_lines <= '0;
			segment_line <= '0;
		end else if (seq_state != SLD_RUN) begin
			common_lines <= '0;
			segment_line <= '0;
		end else begin
			for (int c = 0; c < PHASES; c++) begin
				if (phase == 2'(c)) begin
					common_lines[c*2 +: 2] <= invert ? LVL_GND : LVL_TOP;
				end else begin
					common_lines[c*2 +: 2] <= mid_com;
				end
			end
			for (int s = 0; s < RAM_WORDS; s++) begin
				if (s >= 24 && port3_segment_share) begin
					segment_line[s*2 +: 2] <= LVL_GND;
				end else if (dots[s*4 + phase]) begin
					segment_line[s*2 +: 2] <= invert ? LVL_TOP : LVL_GND;
				end else begin
					segment_line[s*2 +: 2] <= off_seg;
				end
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_off_quiet;
		@(posedge aclk) disable iff (!aresetn)
		!panel_driver_on ##1 !panel_driver_on |=> common_lines == 8'h00;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("outputs active while driver off");

	property p_bias_follow;
		@(posedge aclk) disable iff (!aresetn)
		1 |=> panel_half_bias == $past(panel_mode_reg[MODE_BIAS_BIT]);
	endproperty
	a_bias_follow: assert property (p_bias_follow)
		else $error("bias output does not follow mode register");

	property p_pump_follow;
		@(posedge aclk) disable iff (!aresetn)
		1 |=> pump_enable == $past(pump_voltage_reg[VOLT_PUMP_BIT])
			&& pump_level_sel == $past(pump_voltage_reg[3:1]);
	endproperty
	a_pump_follow: assert property (p_pump_follow)
		else $error("pump outputs do not follow voltage register");

	property p_phase_step;
		@(posedge aclk) disable iff (!aresetn)
		(seq_state == SLD_RUN && panel_driver_on && losc_tick
			&& phase_cnt == 7'd127) |=> phase == $past(phase) + 2'd1;
	endproperty
	a_phase_step: assert property (p_phase_step)
		else $error("common phase did not advance");

	property p_pump_quiet;
		@(posedge aclk) disable iff (!aresetn)
		!pump_enable |=> !pump_clk_en;
	endproperty
	a_pump_quiet: assert property (p_pump_quiet)
		else $error("pump clock runs while pump disabled");

	property p_idle_start;
		@(posedge aclk) disable iff (!aresetn)
		(seq_state == SLD_IDLE && panel_driver_on) |=> seq_state == SLD_RUN;
	endproperty
	a_idle_start: assert property (p_idle_start)
		else $error("sequencer did not start on enable");

	property p_share_gnd;
		@(posedge aclk) disable iff (!aresetn)
		port3_segment_share ##1 port3_segment_share
			|=> segment_line[63:48] == 16'h0000;
	endproperty
	a_share_gnd: assert property (p_share_gnd)
		else $error("shared segments still driven");

	property p_rc_follow;
		@(posedge aclk) disable iff (!aresetn)
		1 |=> losc_rc_sel == $past(panel_mode_reg[MODE_RCCLK_BIT]);
	endproperty
	a_rc_follow: assert property (p_rc_follow)
		else $error("clock type output does not follow mode register");
endmodule : sld_top
`default_nettype wire

// ---- verif/sld_panel_model.sv ----
// passive glass model: decodes which dots glow in each common phase
// assumes two-bit level codes per pin, 0 ground and 3 top
`default_nettype none
module sld_panel_model
	import sld_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         losc_pin,
	input  wire logic [7:0]   common_lines,
	input  wire logic [63:0]  segment_line,
	output logic      [127:0] lit_map,
	output int                phase_len,
	output int                phase_count
);
	timeunit 1ns;
	timeprecision 1ps;
	int tot = 0;
	int last = 0;
	int prev = -1;
	int act;
	initial begin
		lit_map = '0;
		phase_len = 0;
		phase_count = 0;
	end
	// ********************************
	// phase decode
	// ********************************
	// the lone common at an extreme is the scanned one; none when idle
	function automatic int active_com(input logic [7:0] c);
		int n;
		n = 0;
		active_com = -1;
		for (int i = 0; i < 4; i++) begin
			if (c[2*i+:2] == LVL_TOP || c[2*i+:2] == LVL_GND) begin
				n++;
				active_com = i;
			end
		end
		return (n == 1) ? active_com : -1;
	endfunction : active_com
	always @(posedge losc_pin) tot <= tot + 1;
	// glow needs opposite extremes; short glitches between phases ignored
	always @(posedge aclk) begin
		act = active_com(common_lines);
		if (act >= 0) begin
			for (int s = 0; s < 32; s++)
				lit_map[s*4+act] <= (common_lines[2*act+:2] ^
					segment_line[2*s+:2]) == 2'b11;
			if (act != prev) begin
				phase_len <= tot - last;
				phase_count <= phase_count + 1;
				last <= tot;
			end
			prev = act;
		end
	end
endmodule : sld_panel_model
`default_nettype wire

// ---- verif/segment_lcd_driver_tb_top.sv ----
// self-checking bench of the segment lcd driver with a glass model
// assumes sld_pkg, sld_top and sld_panel_model are compiled first
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	err_total++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
	end end
module segment_lcd_driver_tb_top import sld_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic         aclk, aresetn, losc, awvalid, wvalid, bready, arvalid;
	logic         rready, awready, wready, bvalid, arready, rvalid;
	logic         share, rcsel, half, pen, pclk;
	logic [13:0]  awaddr, araddr;
	logic [31:0]  wdata, rdata;
	logic [3:0]   wstrb;
	logic [1:0]   bresp, rresp, pcs, wr_resp;
	logic [2:0]   plv;
	logic [7:0]   com;
	logic [63:0]  seg;
	logic [127:0] lit;
	logic [7:0]   shadow [32];
	int           plen, pcnt, err_total, comparisons, pump_cnt, losc_cnt;
	sld_top i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .losc_pin(losc),
		.common_lines(com), .segment_line(seg),
		.port3_segment_share(share), .losc_rc_sel(rcsel),
		.panel_half_bias(half), .pump_clock_sel(pcs),
		.pump_level_sel(plv), .pump_enable(pen), .pump_clk_en(pclk));
	sld_panel_model i_panel (.aclk(aclk), .losc_pin(losc),
		.common_lines(com), .segment_line(seg), .lit_map(lit),
		.phase_len(plen), .phase_count(pcnt));
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// low-speed source far faster than real, to keep frames short
	initial begin
		losc = 1'b0;
		forever #103 losc = ~losc;
	end
	always @(posedge losc) losc_cnt <= losc_cnt + 1;
	always @(posedge aclk) if (pclk === 1'b1) pump_cnt <= pump_cnt + 1;
	// ********************************
	// tasks and expectations
	// ********************************
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic too_long;
		err_total++;
		$display("[FAIL] wait expected done seen timeout");
		stop_test();
	endtask : too_long
	task automatic test_end(input string t);
		$display("test %s done", t);
	endtask : test_end
	task automatic axi_wr(input logic [13:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		wr_resp = bresp;
		bready <= 1'b0;
		if (n >= 100) too_long();
	endtask : axi_wr
	task automatic axi_rd(input logic [13:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 100) too_long();
	endtask : axi_rd
	task automatic wait_losc(input int e);
		int l0, n;
		l0 = losc_cnt;
		n = 0;
		while (losc_cnt < l0 + e && n < 5000) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 5000) too_long();
	endtask : wait_losc
	// mode change, then nine phases so every common row is refreshed
	task automatic show(input logic [7:0] m);
		int c0, n;
		axi_wr(MODE_ADDR, {24'h0, m});
		c0 = pcnt;
		n = 0;
		while (pcnt < c0 + 9 && n < 20000) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 20000) too_long();
	endtask : show
	function automatic logic [127:0] exp_dots();
		logic [127:0] m;
		for (int s = 0; s < 32; s++) m[s*4+:4] = shadow[s][3:0];
		return m;
	endfunction : exp_dots
	function automatic int exp_pulses(input logic [1:0] ck, input int e);
		int dv [4] = '{1, 2, 8, 32};
		return e / dv[ck];
	endfunction : exp_pulses
	// ********************************
	// main sequence
	// ********************************
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  v;
		int          n, p0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{err_total, comparisons, pump_cnt, losc_cnt} = '0;
		void'($urandom(79886));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		axi_rd(MODE_ADDR, d, r);
		`CHK("mode reset", 32'h0, d)
		axi_rd(VOLT_ADDR, d, r);
		`CHK("volt reset", 32'h0, d)
		`CHK("idle commons", 8'h00, com)
		`CHK("idle segments", 64'h0, seg)
		test_end("reset");
		for (int i = 0; i < 16; i++) begin
			v = {4'($urandom), 4'(i)};
			axi_wr(MODE_ADDR, {24'($urandom), v});
			axi_rd(MODE_ADDR, d, r);
			`CHK("mode", {24'h0, v & MODE_MASK}, d)
			`CHK("rc select", v[3], rcsel)
			`CHK("share", v[2], share)
			`CHK("half bias", v[1], half)
		end
		axi_wr(MODE_ADDR, 32'h0);
		for (int i = 0; i < 64; i++) begin
			v = {2'($urandom), 6'(i)};
			axi_wr(VOLT_ADDR, {24'h0, v});
			axi_rd(VOLT_ADDR, d, r);
			`CHK("volt", {24'h0, v & VOLT_MASK}, d)
			`CHK("pump clock", v[5:4], pcs)
			`CHK("pump level", v[3:1], plv)
			`CHK("pump on", v[0], pen)
		end
		axi_rd(14'h0000, d, r);
		`CHK("unmapped resp", RESP_SLVERR, r)
		`CHK("unmapped data", 32'h0, d)
		axi_wr(14'h0000, 32'h0000005A);
		`CHK("unmapped bresp", RESP_SLVERR, wr_resp)
		test_end("fields");
		for (int s = 0; s < 32; s++) begin
			shadow[s] = s == 0 ? 8'h0F : s == 31 ? 8'hF0 : 8'($urandom);
			axi_wr(RAM_ADDR_BASE + 14'(4 * s), {24'h0, shadow[s]});
			`CHK("ram bresp", RESP_OKAY, wr_resp)
		end
		for (int s = 0; s < 32; s++) begin
			axi_rd(RAM_ADDR_BASE + 14'(4 * s), d, r);
			`CHK("ram byte", {24'h0, shadow[s]}, d)
			`CHK("ram rresp", RESP_OKAY, r)
		end
		test_end("ram");
		axi_wr(VOLT_ADDR, 32'h0);
		show(8'h01);
		`CHK("third bias dots", exp_dots(), lit)
		`CHK("phase length", 32768 / (64 * 4), plen)
		show(8'h03);
		`CHK("half bias dots", exp_dots(), lit)
		axi_wr(VOLT_ADDR, {24'h0, 8'h0F});
		show(8'h01);
		`CHK("pump mode dots", exp_dots(), lit)
		show(8'h05);
		`CHK("shared segments", 16'h0, seg[63:48])
		test_end("display");
		axi_wr(MODE_ADDR, 32'h0);
		repeat (4) @(posedge aclk);
		`CHK("off commons", 8'h00, com)
		`CHK("off segments", 64'h0, seg)
		n = pcnt;
		wait_losc(300);
		`CHK("sequencer idle", n, pcnt)
		for (int k = 0; k < 4; k++) begin
			axi_wr(VOLT_ADDR, {26'h0, 2'(k), 4'b0001});
			p0 = pump_cnt;
			wait_losc(128);
			n = pump_cnt - p0 - exp_pulses(2'(k), 128);
			`CHK("pump rate", 1'b1, n >= -1 && n <= 1)
		end
		axi_wr(VOLT_ADDR, 32'h0);
		repeat (4) @(posedge aclk);
		p0 = pump_cnt;
		wait_losc(128);
		`CHK("pump stopped", p0, pump_cnt)
		test_end("pump");
		stop_test();
	end
endmodule : segment_lcd_driver_tb_top
`default_nettype wire
